// [core/mid_core.sv]
/*
  Move-instruction decoder and operand addressing for a 16-bit
  accumulator core: prefix handling, system modules (arithmetic,
  accumulators, program flow, stack, data and frame pointers).
  Assumes program memory answers PROG_DATA for PROG_ADDR in the same
  cycle, data memory has three combinational read ports and one write
  port, and peripheral modules decode their own source from PROG_DATA
  and PFX_VALUE and answer on PERI_RDATA in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////
module mid_core #(
  parameter int unsigned NUM_ACC     = 16,
  parameter int unsigned STACK_DEPTH = 16
) (
  // Clock and reset.
  input  wire  logic                 CORE_CLK,
  input  wire  logic                 NRST,
  // Program memory.
  output var   logic [15:0]          PROG_ADDR,
  input  wire  logic [15:0]          PROG_DATA,
  // Data memory: read port per pointer, one write port.
  output var   logic [2:0][15:0]     DMEM_RADDR,
  input  wire  logic [2:0][15:0]     DMEM_RDATA,
  output var   logic                 DMEM_WE,
  output var   logic [15:0]          DMEM_WADDR,
  output var   logic [15:0]          DMEM_WDATA,
  // Peripheral register modules.
  output var   logic [7:0]           PFX_VALUE,
  input  wire  logic [15:0]          PERI_RDATA,
  input  wire  logic                 PERI_RWIDE,
  output var   logic                 PERI_WE,
  output var   logic [3:0]           PERI_WMOD,
  output var   logic [4:0]           PERI_WIDX,
  output var   logic [15:0]          PERI_WDATA
);

  ////////////////////////////////////////////////////////////////////
  // State.
  logic [15:0]               ip_r;
  logic [7:0]                prefix_register_r;
  logic [15:0]               acc_r [NUM_ACC];
  logic [3:0]                ap_r;
  logic                      carry_r;
  logic                      zero_r;
  logic [15:0]               stack_r [STACK_DEPTH];
  logic [3:0]                sp_r;
  logic [2:0][15:0]          ptr_r;
  logic [7:0]                frame_offset_r;

  // Decoded fields.
  logic                      fmt;
  logic [3:0]                dst_mod;
  logic [4:0]                dst_idx;
  logic [3:0]                src_mod;
  logic [4:0]                src_idx;

  // Source side.
  logic [15:0]               src_val;
  logic                      pop_hit;
  logic [2:0]                rd_hit;
  logic [2:0][1:0]           rd_mode;

  // Destination side.
  logic                      push_hit;
  logic [2:0]                wr_hit;
  logic [2:0][1:0]           wr_mode;
  logic [2:0][15:0]          ptr_nxt;
  logic [7:0]                frame_offset_nxt;
  logic [15:0]               dm_waddr_nxt;
  logic [16:0]               alu_res;
  logic [15:0]               ip_nxt;
  logic [15:0]               stack_top;

  // Register slot of a pointer access mode.
  function automatic logic [4:0] ptr_slot(input int unsigned p, input logic [1:0] m);
    ptr_slot = mid_pkg::IDX_PACC + 5'(3 * p) + {3'h0, m};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Field split of the one-word instruction.
  // single word decode
  always_comb
  begin
    fmt     = PROG_DATA[mid_pkg::FMT_BIT];
    dst_mod = PROG_DATA[mid_pkg::DST_MOD_HI:mid_pkg::DST_MOD_LO];
    dst_idx = {prefix_register_r[mid_pkg::PFX_DST_HI:mid_pkg::PFX_DST_LO],
               PROG_DATA[mid_pkg::DST_IDX_HI:mid_pkg::DST_IDX_LO]};
    src_mod = PROG_DATA[mid_pkg::SRC_MOD_HI:mid_pkg::SRC_MOD_LO];
    src_idx = {prefix_register_r[mid_pkg::PFX_SRC_BIT],
               PROG_DATA[mid_pkg::SRC_IDX_HI:mid_pkg::SRC_IDX_LO]};
  end

  assign stack_top = stack_r[4'(sp_r - 4'h1)];

  ////////////////////////////////////////////////////////////////////
  // Source value. Narrow registers other than the prefix itself take the
  // prefix as their high byte; undefined system locations read as zero,
  // with no prefix in their high byte.
  always_comb
  begin
    src_val = 16'h0000;
    pop_hit = 1'b0;
    rd_hit  = 3'h0;
    rd_mode = '0;
    if (!fmt)
      src_val = {prefix_register_r, PROG_DATA[7:0]};
    else if (src_mod <= mid_pkg::PERI_MOD_LAST)
      src_val = PERI_RWIDE ? PERI_RDATA : {prefix_register_r, PERI_RDATA[7:0]};
    else
    begin
      unique case (src_mod)
        mid_pkg::MOD_ALU:
        begin
          if (src_idx == mid_pkg::IDX_AP)
            src_val = {prefix_register_r, 4'h0, ap_r};
          else if (src_idx == mid_pkg::IDX_FLAGS)
            src_val = {prefix_register_r, 6'h00, zero_r, carry_r};
        end
        mid_pkg::MOD_ACC:
          if (src_idx < 5'(NUM_ACC))
            src_val = acc_r[src_idx[3:0]];
        mid_pkg::MOD_PFX:
          if (src_idx == mid_pkg::IDX_PFX)
            src_val = {8'h00, prefix_register_r};
        mid_pkg::MOD_FLOW:
        begin
          if (src_idx == mid_pkg::IDX_IP)
            src_val = ip_r;
          else if (src_idx == mid_pkg::IDX_SP)
            src_val = {prefix_register_r, 4'h0, sp_r};
          else if (src_idx == mid_pkg::IDX_STACK)
          begin
            src_val = stack_top;
            pop_hit = 1'b1;
          end
        end
        mid_pkg::MOD_PTR:
        begin
          if (src_idx <= mid_pkg::IDX_BP)
            src_val = ptr_r[src_idx[1:0]];
          else if (src_idx == mid_pkg::IDX_FRAME_OFFSET)
            src_val = {prefix_register_r, frame_offset_r};
          for (int unsigned p = 0; p < 3; p++)
            for (int unsigned m = 0; m < 3; m++)
              if (src_idx == ptr_slot(p, 2'(m)))
              begin
                // A store in its strobe cycle lands only at the closing edge,
                // so it is forwarded here or the next word would read stale data.
                src_val    = (DMEM_WE && DMEM_WADDR == DMEM_RADDR[p]) ? DMEM_WDATA :
                             DMEM_RDATA[p];
                rd_hit[p]  = 1'b1;
                rd_mode[p] = 2'(m);
              end
        end
        default:
          src_val = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Destination side effects decoded from module and index.
  always_comb
  begin
    push_hit = 1'b0;
    wr_hit   = 3'h0;
    wr_mode  = '0;
    if (dst_mod == mid_pkg::MOD_FLOW && dst_idx == mid_pkg::IDX_STACK)
      push_hit = 1'b1;
    if (dst_mod == mid_pkg::MOD_PTR)
      for (int unsigned p = 0; p < 3; p++)
        for (int unsigned m = 0; m < 3; m++)
          if (dst_idx == ptr_slot(p, 2'(m)))
          begin
            wr_hit[p]  = 1'b1;
            wr_mode[p] = 2'(m);
          end
  end

  ////////////////////////////////////////////////////////////////////
  // Pointer stepping. A write access wins over a read access of the same
  // pointer, since the pre-step must land before the store address.
  // post-step reads, pre-step writes
  always_comb
  begin
    ptr_nxt          = ptr_r;
    frame_offset_nxt = frame_offset_r;
    dm_waddr_nxt     = 16'h0000;
    for (int unsigned p = 0; p < 3; p++)
    begin
      if ((wr_hit[p] && wr_mode[p] != mid_pkg::PM_PLAIN) ||
          (!wr_hit[p] && rd_hit[p] && rd_mode[p] != mid_pkg::PM_PLAIN))
      begin
        if (p == 2)
          frame_offset_nxt = ((wr_hit[p] ? wr_mode[p] : rd_mode[p]) == mid_pkg::PM_INC) ?
                             8'(frame_offset_r + 8'h01) : 8'(frame_offset_r - 8'h01);
        else
          ptr_nxt[p] = ((wr_hit[p] ? wr_mode[p] : rd_mode[p]) == mid_pkg::PM_INC) ?
                       16'(ptr_r[p] + 16'h0001) : 16'(ptr_r[p] - 16'h0001);
      end
      if (wr_hit[p])
        dm_waddr_nxt = (p == 2) ? 16'(ptr_nxt[2] + {8'h00, frame_offset_nxt}) : ptr_nxt[p];
    end
    // Direct loads of the pointer registers override any stepping.
    if (dst_mod == mid_pkg::MOD_PTR)
    begin
      if (dst_idx <= mid_pkg::IDX_BP)
        ptr_nxt[dst_idx[1:0]] = src_val;
      else if (dst_idx == mid_pkg::IDX_FRAME_OFFSET)
        frame_offset_nxt = src_val[7:0];
    end
  end

  // frame address is base plus offset
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ptr_r          <= '0;
      frame_offset_r <= 8'h00;
      DMEM_RADDR     <= '0;
    end
    else
    begin
      ptr_r          <= ptr_nxt;
      frame_offset_r <= frame_offset_nxt;
      DMEM_RADDR[0]  <= ptr_nxt[0];
      DMEM_RADDR[1]  <= ptr_nxt[1];
      DMEM_RADDR[2]  <= 16'(ptr_nxt[2] + {8'h00, frame_offset_nxt});
    end
  end

  // Data memory store, issued one cycle after the move.
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      DMEM_WE    <= 1'b0;
      DMEM_WADDR <= 16'h0000;
      DMEM_WDATA <= 16'h0000;
    end
    else
    begin
      DMEM_WE    <= |wr_hit;
      DMEM_WADDR <= dm_waddr_nxt;
      DMEM_WDATA <= src_val;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Prefix register: lives for exactly one instruction.
  // prefix clears after one cycle
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      prefix_register_r <= mid_pkg::PFX_RST;
    else if (dst_mod == mid_pkg::MOD_PFX && dst_idx == mid_pkg::IDX_PFX)
      prefix_register_r <= src_val[7:0];
    else
      prefix_register_r <= mid_pkg::PFX_RST;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      PFX_VALUE <= mid_pkg::PFX_RST;
    else if (dst_mod == mid_pkg::MOD_PFX && dst_idx == mid_pkg::IDX_PFX)
      PFX_VALUE <= src_val[7:0];
    else
      PFX_VALUE <= mid_pkg::PFX_RST;
  end

  ////////////////////////////////////////////////////////////////////
  // Arithmetic on the active accumulator with any source.
  // operation by move side effect
  always_comb
  begin
    unique case (dst_idx)
      mid_pkg::IDX_ADD:  alu_res = {1'b0, acc_r[ap_r]} + {1'b0, src_val};
      mid_pkg::IDX_ADD_WITH_CARRY_OP: alu_res = {1'b0, acc_r[ap_r]} + {1'b0, src_val} + {16'h0000, carry_r};
      mid_pkg::IDX_SUB:  alu_res = {1'b0, acc_r[ap_r]} - {1'b0, src_val};
      mid_pkg::IDX_OR:   alu_res = {carry_r, acc_r[ap_r] | src_val};
      mid_pkg::IDX_AND:  alu_res = {carry_r, acc_r[ap_r] & src_val};
      mid_pkg::IDX_XOR:  alu_res = {carry_r, acc_r[ap_r] ^ src_val};
      default:           alu_res = {carry_r, acc_r[ap_r]};
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int unsigned i = 0; i < NUM_ACC; i++)
        acc_r[i] <= 16'h0000;
      ap_r    <= 4'h0;
      carry_r <= 1'b0;
      zero_r  <= 1'b0;
    end
    else if (dst_mod == mid_pkg::MOD_ACC && dst_idx < 5'(NUM_ACC))
      acc_r[dst_idx[3:0]] <= src_val;
    else if (dst_mod == mid_pkg::MOD_ALU)
    begin
      if (dst_idx == mid_pkg::IDX_AP)
        ap_r <= src_val[3:0];
      else if (dst_idx >= mid_pkg::IDX_ADD && dst_idx <= mid_pkg::IDX_SUB)
      begin
        acc_r[ap_r] <= alu_res[15:0];
        carry_r     <= alu_res[16];
        zero_r      <= (alu_res[15:0] == 16'h0000);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program flow: one word fetched and executed every cycle.
  // one cycle per word
  always_comb
  begin
    ip_nxt = 16'(ip_r + 16'h0001);
    if (dst_mod == mid_pkg::MOD_FLOW && dst_idx == mid_pkg::IDX_IP)
      ip_nxt = src_val;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      ip_r <= mid_pkg::IP_RST;
    else
      ip_r <= ip_nxt;
  end

  assign PROG_ADDR = ip_r;

  // Stack: pop reads the top, push stores above it; both together replace it.
  // sixteen-entry word stack
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sp_r <= 4'h0;
      for (int unsigned i = 0; i < STACK_DEPTH; i++)
        stack_r[i] <= 16'h0000;
    end
    else if (push_hit && pop_hit)
      stack_r[4'(sp_r - 4'h1)] <= src_val;
    else if (push_hit)
    begin
      stack_r[sp_r] <= src_val;
      sp_r          <= 4'(sp_r + 4'h1);
    end
    else if (pop_hit)
      sp_r <= 4'(sp_r - 4'h1);
  end

  ////////////////////////////////////////////////////////////////////
  // Peripheral register writes, presented one cycle after the move.
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PERI_WE    <= 1'b0;
      PERI_WMOD  <= 4'h0;
      PERI_WIDX  <= 5'h00;
      PERI_WDATA <= 16'h0000;
    end
    else
    begin
      PERI_WE    <= (dst_mod <= mid_pkg::PERI_MOD_LAST);
      PERI_WMOD  <= dst_mod;
      PERI_WIDX  <= dst_idx;
      PERI_WDATA <= src_val;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  AST_PFX_CLEARS:
    assert property (!(dst_mod == mid_pkg::MOD_PFX && dst_idx == mid_pkg::IDX_PFX)
                     |=> prefix_register_r == 8'h00)
    else $error("prefix survived past one instruction");

  AST_IMM_WIDE:
    assert property (!fmt && dst_mod == mid_pkg::MOD_ACC && dst_idx == 5'h00
                     |=> acc_r[0] == {$past(prefix_register_r), $past(PROG_DATA[7:0])})
    else $error("immediate did not combine prefix and low byte");

  AST_IP_STEP:
    assert property (!(dst_mod == mid_pkg::MOD_FLOW && dst_idx == mid_pkg::IDX_IP)
                     |=> ip_r == 16'($past(ip_r) + 16'h0001))
    else $error("instruction pointer did not advance by one");

  AST_JUMP:
    assert property (dst_mod == mid_pkg::MOD_FLOW && dst_idx == mid_pkg::IDX_IP
                     |=> PROG_ADDR == $past(src_val))
    else $error("jump target not fetched next");

  AST_POST_INC:
    assert property (rd_hit[0] && rd_mode[0] == mid_pkg::PM_INC && !wr_hit[0] &&
                     dst_mod != mid_pkg::MOD_PTR
                     |=> ptr_r[0] == 16'($past(ptr_r[0]) + 16'h0001))
    else $error("read did not post-increment pointer");

  AST_PRE_DEC:
    assert property (wr_hit[1] && wr_mode[1] == mid_pkg::PM_DEC
                     |=> DMEM_WE && DMEM_WADDR == 16'($past(ptr_r[1]) - 16'h0001))
    else $error("write did not use pre-decremented address");

  AST_BASE_KEPT:
    assert property ((rd_hit[2] || wr_hit[2]) && dst_mod != mid_pkg::MOD_PTR
                     |=> $stable(ptr_r[2]))
    else $error("frame step altered the base pointer");

  AST_STACK_PUSH:
    assert property (push_hit && !pop_hit |=> sp_r == 4'($past(sp_r) + 4'h1))
    else $error("push did not advance stack pointer");

  AST_PERI_WRITE:
    assert property (dst_mod <= mid_pkg::PERI_MOD_LAST
                     |=> PERI_WE && PERI_WMOD == $past(dst_mod) &&
                         PERI_WIDX[2:0] == $past(PROG_DATA[14:12]))
    else $error("peripheral write lost its destination");

endmodule

`default_nettype wire

// [core/mid_pkg.sv]
/*
  Constants shared by the move-instruction decoder: instruction field
  positions, system-module numbers and register indices, reset values.
  Assumes a single 16-bit core clock domain; nothing here holds logic.
*/
`default_nettype none

package mid_pkg;

  // Instruction word fields.
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned FMT_BIT     = 15;
  localparam int unsigned DST_IDX_HI  = 14;
  localparam int unsigned DST_IDX_LO  = 12;
  localparam int unsigned DST_MOD_HI  = 11;
  localparam int unsigned DST_MOD_LO  = 8;
  localparam int unsigned SRC_IDX_HI  = 7;
  localparam int unsigned SRC_IDX_LO  = 4;
  localparam int unsigned SRC_MOD_HI  = 3;
  localparam int unsigned SRC_MOD_LO  = 0;

  // Prefix bits that extend the register indices.
  localparam int unsigned PFX_SRC_BIT = 4;
  localparam int unsigned PFX_DST_LO  = 5;
  localparam int unsigned PFX_DST_HI  = 6;

  // Register modules; modules up to PERI_MOD_LAST live outside the core.
  localparam logic [3:0] PERI_MOD_LAST = 4'h7;
  localparam logic [3:0] MOD_ALU       = 4'h8;
  localparam logic [3:0] MOD_ACC       = 4'h9;
  localparam logic [3:0] MOD_PFX       = 4'hB;
  localparam logic [3:0] MOD_FLOW      = 4'hC;
  localparam logic [3:0] MOD_PTR       = 4'hF;

  // Arithmetic module indices.
  localparam logic [4:0] IDX_AP    = 5'h00;
  localparam logic [4:0] IDX_ADD   = 5'h01;
  localparam logic [4:0] IDX_ADD_WITH_CARRY_OP  = 5'h02;
  localparam logic [4:0] IDX_OR    = 5'h03;
  localparam logic [4:0] IDX_AND   = 5'h04;
  localparam logic [4:0] IDX_XOR   = 5'h05;
  localparam logic [4:0] IDX_SUB   = 5'h06;
  localparam logic [4:0] IDX_FLAGS = 5'h07;

  // Prefix, program flow and pointer module indices.
  localparam logic [4:0] IDX_PFX   = 5'h00;
  localparam logic [4:0] IDX_IP    = 5'h00;
  localparam logic [4:0] IDX_STACK = 5'h01;
  localparam logic [4:0] IDX_SP    = 5'h02;
  localparam logic [4:0] IDX_DP0   = 5'h00;
  localparam logic [4:0] IDX_DP1   = 5'h01;
  localparam logic [4:0] IDX_BP    = 5'h02;
  localparam logic [4:0] IDX_FRAME_OFFSET  = 5'h03;
  localparam logic [4:0] IDX_PACC  = 5'h04;

  // Pointer access modes, added to IDX_PACC + 3 * pointer.
  localparam logic [1:0] PM_PLAIN = 2'h0;
  localparam logic [1:0] PM_INC   = 2'h1;
  localparam logic [1:0] PM_DEC   = 2'h2;

  // Reset values.
  localparam logic [15:0] IP_RST  = 16'h0000;
  localparam logic [7:0]  PFX_RST = 8'h00;

endpackage

`default_nettype wire

// [tb/mid_partner.sv]
/*
  Program memory, data memory and peripheral modules facing mid_core.
  Assumes the bench fills both memories before reset is released.
*/
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module mid_partner (
  // Core side.
  input  wire logic             clk,
  input  wire logic [15:0]      prog_addr,
  output var  logic [15:0]      prog_data,
  input  wire logic [2:0][15:0] dmem_raddr,
  output var  logic [2:0][15:0] dmem_rdata,
  input  wire logic             dmem_we,
  input  wire logic [15:0]      dmem_waddr,
  input  wire logic [15:0]      dmem_wdata,
  output var  logic [15:0]      peri_rdata,
  output var  logic             peri_rwide
);
  logic [15:0] prog [256];
  logic [15:0] dmem [512];
  logic [15:0] junk_r = 16'h5A5A;
  logic        sel;

  always_comb
  begin
    prog_data = prog[prog_addr[7:0]];
    for (int k = 0; k < 3; k++)
      dmem_rdata[k] = dmem[dmem_raddr[k][8:0]];
  end

  // Unselected peripherals show a changing pattern, never the last value.
  always_comb
  begin
    sel = prog_data[15] && !prog_data[3];
    peri_rdata = sel ? {prog_data[7:0], prog_data[7:0] ^ 8'h3C} : junk_r;
    peri_rwide = sel ? !prog_data[4] : junk_r[0];
  end

  // Data memory stores on the edge where the strobe is high.
  always @(posedge clk)
  begin
    junk_r <= ~junk_r + 16'h0001;
    if (dmem_we)
      dmem[dmem_waddr[8:0]] <= dmem_wdata;
  end
endmodule
`default_nettype wire

// [tb/tb_mid_core.sv]
/*
  Self-checking bench for mid_core: builds a program, runs it, and
  compares every peripheral and data-memory write. Assumes mid_partner.
*/
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module tb_mid_core;
  logic             CORE_CLK = 1'b0;
  logic             NRST = 1'b0;
  logic [15:0]      PROG_ADDR, PROG_DATA, PERI_RDATA, PERI_WDATA;
  logic [15:0]      DMEM_WADDR, DMEM_WDATA;
  logic [2:0][15:0] DMEM_RADDR, DMEM_RDATA;
  logic             DMEM_WE, PERI_RWIDE, PERI_WE;
  logic [7:0]       PFX_VALUE, p, v, pfx_exp;
  logic [15:0]      r;
  logic             c;
  logic [3:0]       PERI_WMOD;
  logic [4:0]       PERI_WIDX;
  logic [39:0]      exp_q[$], got_q[$];
  logic [15:0]      acc [16];
  int               n_mismatch = 0, checked = 0, cyc = 0, pc = 0, a;

  mid_core mid_core_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .DMEM_RADDR(DMEM_RADDR), .DMEM_RDATA(DMEM_RDATA),
    .DMEM_WE(DMEM_WE), .DMEM_WADDR(DMEM_WADDR), .DMEM_WDATA(DMEM_WDATA),
    .PFX_VALUE(PFX_VALUE), .PERI_RDATA(PERI_RDATA), .PERI_RWIDE(PERI_RWIDE),
    .PERI_WE(PERI_WE), .PERI_WMOD(PERI_WMOD), .PERI_WIDX(PERI_WIDX), .PERI_WDATA(PERI_WDATA));

  mid_partner mid_partner_inst (.clk(CORE_CLK), .prog_addr(PROG_ADDR), .prog_data(PROG_DATA),
    .dmem_raddr(DMEM_RADDR), .dmem_rdata(DMEM_RDATA), .dmem_we(DMEM_WE),
    .dmem_waddr(DMEM_WADDR), .dmem_wdata(DMEM_WDATA), .peri_rdata(PERI_RDATA),
    .peri_rwide(PERI_RWIDE));

  always #4 CORE_CLK = ~CORE_CLK;

  // Strobes stand one whole cycle, so the falling edge records each once.
  always @(negedge CORE_CLK)
  begin
    if (PERI_WE === 1'b1)
      got_q.push_back({8'h01, 7'h00, PERI_WMOD, PERI_WIDX, PERI_WDATA});
    if (DMEM_WE === 1'b1)
      got_q.push_back({8'h02, DMEM_WADDR, DMEM_WDATA});
    if (NRST === 1'b1)
      cmp({32'h0, pfx_exp}, {32'h0, PFX_VALUE});
  end

  // A hung program is cut short and counted as a mismatch.
  // The prefix output mirrors only the word just executed when it loads the prefix.
  always @(posedge CORE_CLK)
  begin
    pfx_exp <= (NRST === 1'b1 && PROG_DATA[15:8] == 8'h0B) ? PROG_DATA[7:0] : 8'h00;
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  function automatic logic [15:0] wd(logic f, logic [2:0] di, logic [3:0] dm, logic [7:0] s);
    return {f, di, dm, s};
  endfunction

  function automatic logic [15:0] dmi(logic [15:0] ad);
    return {ad[7:0] ^ 8'h5A, ad[7:0]};
  endfunction

  // Places a word, after a prefix word when the prefix is nonzero.
  task automatic put(logic [7:0] pf, logic [15:0] w);
    if (pf !== 8'h00)
    begin
      mid_partner_inst.prog[pc] = {8'h0B, pf};
      pc++;
    end
    mid_partner_inst.prog[pc] = w;
    pc++;
  endtask

  task automatic xp(logic [7:0] tg, logic [15:0] ad, logic [15:0] d);
    exp_q.push_back({tg, ad, d});
  endtask

  // A move into a peripheral; the prefix extends the destination index.
  task automatic mvp(logic [7:0] pf, logic f, logic [2:0] di, logic [3:0] dm,
                     logic [7:0] s, logic [15:0] d);
    put(pf, wd(f, di, dm, s));
    xp(8'h01, {7'h00, dm, pf[6:5], di}, d);
  endtask

  task automatic cmp(logic [39:0] e, logic [39:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic test_done();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Unused program words write an undefined location and change nothing.
  initial
  begin
    void'($urandom(59623));
    for (a = 0; a < 256; a++)
      mid_partner_inst.prog[a] = 16'h0A00;
    for (a = 0; a < 512; a++)
      mid_partner_inst.dmem[a] = dmi(16'(a));
    repeat (6)
    begin
      v = 8'($urandom);
      mvp(8'h00, 1'b0, 3'($urandom), 4'($urandom_range(7)), v, {8'h00, v});
    end
    repeat (4)
    begin
      p = 8'($urandom);
      v = 8'($urandom);
      mvp(p, 1'b0, 3'($urandom), 4'h1, v, {p, v});
      mvp(8'h00, 1'b0, 3'h2, 4'h1, v, {8'h00, v});
      v = {4'($urandom), 1'b0, 3'($urandom)};
      mvp(p, 1'b1, 3'h5, 4'h2, v, v[4] ? {p, v ^ 8'h3C} : {v, v ^ 8'h3C});
    end
    // Upper accumulators need prefix bit 5 to reach their destination index.
    for (a = 0; a < 16; a++)
    begin
      acc[a] = {2'b10, a[3], 5'($urandom), 8'($urandom)};
      put(acc[a][15:8], wd(1'b0, a[2:0], 4'h9, acc[a][7:0]));
    end
    for (a = 0; a < 16; a++)
      mvp(8'h00, 1'b1, 3'h3, 4'h1, {a[3:0], 4'h9}, acc[a]);
    // Accumulator 3 adds accumulator 5, then ORs an immediate.
    v = 8'($urandom);
    put(8'h00, wd(1'b0, 3'h0, 4'h8, 8'h03));
    put(8'h00, wd(1'b1, 3'h1, 4'h8, 8'h59));
    put(8'h00, wd(1'b0, 3'h3, 4'h8, v));
    mvp(8'h00, 1'b1, 3'h4, 4'h1, 8'h39, (acc[3] + acc[5]) | {8'h00, v});
    // Subtract accumulator 2, then add the borrow back through add with carry.
    {c, r} = {1'b0, ((acc[3] + acc[5]) | {8'h00, v})} - {1'b0, acc[2]};
    put(8'h00, wd(1'b1, 3'h6, 4'h8, 8'h29));
    put(8'h00, wd(1'b0, 3'h2, 4'h8, 8'h00));
    {c, r} = {1'b0, r} + {16'h0000, c};
    mvp(8'h00, 1'b1, 3'h4, 4'h1, 8'h39, r);
    mvp(8'h00, 1'b1, 3'h5, 4'h1, 8'h78, {14'h0000, r == 16'h0000, c});
    // Pointers: post-step on reads, pre-step on writes, frame wraps its offset.
    put(8'h00, wd(1'b0, 3'h0, 4'hF, 8'h40));
    put(8'h00, wd(1'b0, 3'h1, 4'hF, 8'h80));
    mvp(8'h00, 1'b1, 3'h0, 4'h1, 8'h5F, dmi(16'h0040));
    mvp(8'h00, 1'b1, 3'h0, 4'h1, 8'h4F, dmi(16'h0041));
    put(8'h20, wd(1'b0, 3'h1, 4'hF, v));
    xp(8'h02, 16'h007F, {8'h20, v});
    mvp(8'h00, 1'b1, 3'h0, 4'h1, 8'h7F, {8'h20, v});
    put(8'h01, wd(1'b0, 3'h2, 4'hF, 8'h00));
    put(8'h00, wd(1'b0, 3'h3, 4'hF, 8'hFF));
    put(8'h20, wd(1'b0, 3'h3, 4'hF, v));
    xp(8'h02, 16'h0100, {8'h20, v});
    mvp(8'h00, 1'b1, 3'h0, 4'h1, 8'h2F, 16'h0100);
    // Stack returns pushes in reverse order.
    put(8'h00, wd(1'b0, 3'h1, 4'hC, 8'h11));
    put(8'h12, wd(1'b0, 3'h1, 4'hC, 8'h34));
    mvp(8'h00, 1'b1, 3'h1, 4'h1, 8'h1C, 16'h1234);
    mvp(8'h00, 1'b1, 3'h1, 4'h1, 8'h1C, 16'h0011);
    // A jump skips the next word, which must never write.
    put(8'h00, wd(1'b0, 3'h0, 4'hC, 8'(pc + 2)));
    put(8'h00, wd(1'b0, 3'h7, 4'h1, 8'hEE));
    mvp(8'h00, 1'b0, 3'h6, 4'h1, 8'h77, 16'h0077);
    repeat (6)
      @(posedge CORE_CLK);
    #1 NRST = 1'b1;
    while (PROG_ADDR !== 16'(pc + 3))
      @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    cmp({24'h0, 16'(exp_q.size())}, {24'h0, 16'(got_q.size())});
    foreach (exp_q[k])
      cmp(exp_q[k], got_q[k]);
    test_done();
  end
endmodule
`default_nettype wire
